//--- rtl/i2c_rx_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and an AXI4-Lite word-aligned map
//
// Overview of operation
// - receive start bit starts one-byte reception
// - start ignored unless port idle
// - counter rollover toggles clock, shifts data
// - eighth falling edge: load buffer, flags
// - byte end: stop counter, clock low, idle
// - buffer read clears buffer full flag
// - acknowledge sequence start after received byte
// - buffer full set on every received byte
// - overflow when byte lands, buffer full
// - buffer write during shifting sets collision
// - counter holds until clock sampled high
// - reload counter while released clock seen low
// - receive during sleep, wake on byte if irq mask bit set
// - reset disables port, aborts transfer
`ifndef I2C_RX_REGS_SVH
`define I2C_RX_REGS_SVH
`define OFS_CONTROL_ONE   4'h0
`define OFS_CONTROL_TWO   4'h4
`define OFS_RATE          4'h8
`define OFS_BUFFER        4'hc
`define OFS_STATUS        5'h10
`define OFS_MASK          5'h14
`define BIT_ENABLE        0
`define BIT_RECEIVE_START 3
`define BIT_ACK_START     4
`define BIT_ACK_VALUE     5
`define BIT_SLEEP         6
`define ST_BUFFER_FULL    0
`define ST_SERIAL_IRQ     1
`define ST_OVERFLOW       2
`define ST_COLLISION      3
`define RATE_RESET        7'h09
`define EDGES_PER_BYTE    4'h8
`endif

//--- rtl/i2c_rx_pkg.sv
// types shared by the receive path files
// assumes nothing beyond the tool's SystemVerilog support
package i2c_rx_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RX_LOW  = 3'b001,
    ST_RX_HIGH = 3'b010,
    ST_ACK_LOW = 3'b011,
    ST_ACK_HI  = 3'b100,
    ST_ACK_END = 3'b101
  } port_state_e;
  typedef struct packed {
    logic       full;
    logic       irq;
    logic       overflow;
    logic       collision;
  } status_s;
endpackage

//--- rtl/pin_sync.sv
// two-stage synchroniser for a level from outside the clock domain
// assumes clk_sys domain, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output var  logic pinSync
);
  logic firstStage;
  // first stage read only by the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      firstStage <= 1'b1;
      pinSync    <= 1'b1;
    end else begin
      firstStage <= pinIn;
      pinSync    <= firstStage;
    end
  end
endmodule
`default_nettype wire

//--- rtl/rate_counter.sv
// reload-based rate counter with hold and rollover pulse
// assumes clk_sys domain; reload value comes from software
`timescale 1ns/100ps
`default_nettype none
module rate_counter (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       reload,
  input  wire logic [6:0] reloadValue,
  output var  logic       rollover
);
  logic [6:0] count;
  // counts down; rollover at zero then reloads
  always_ff @(posedge clk_sys) begin
    if (sys_rst || reload || !run) begin
      count    <= reloadValue;
      rollover <= 1'b0;
    end else if (count == 7'h00) begin
      count    <= reloadValue;
      rollover <= 1'b1;
    end else begin
      count    <= count - 7'h01;
      rollover <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/i2c_master_receive.sv
// master receive path of a two-wire port with AXI4-Lite registers
// assumes 100 MHz clk_sys, pins are open drain with external pull-ups
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`include "i2c_rx_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module i2c_master_receive (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sclIn,
  output var  logic        sclOut,
  output var  logic        sclOe_n,
  input  wire logic        sdaIn,
  output var  logic        sdaOut,
  output var  logic        sdaOe_n,
  output var  logic        irq,
  output var  logic        wakeUp
);
  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  i2c_rx_pkg::port_state_e state;
  i2c_rx_pkg::status_s     status;
  i2c_rx_pkg::status_s     mask;
  logic       portEnable;
  logic       receiveStart;
  logic       ackStart;
  logic       ackValue;
  logic       sleepMode;
  logic [6:0] rateReload;
  logic [7:0] serialBuffer;
  logic [7:0] shiftIn;
  logic [3:0] bitCount;
  logic       sclDrive;
  logic       sclSync;
  logic       sdaSync;
  logic       sclHeld;
  logic       rollover;
  logic       counterRun;
  logic       counterReload;
  logic       byteDone;
  logic       bufWrite;
  logic       bufRead;
  logic       ctlTwoWrite;
  logic       haveAw;
  logic       haveW;
  logic [4:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic       doWrite;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  pin_sync u_scl_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pinIn   (sclIn),
    .pinSync (sclSync)
  );
  pin_sync u_sda_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pinIn   (sdaIn),
    .pinSync (sdaSync)
  );

  // ------------------------------------------------------------
  // rate counter with clock arbitration
  // ------------------------------------------------------------
  // released clock waits for the line to be seen high
  assign sclHeld = sclDrive && !sclSync;
  assign counterRun = (state != i2c_rx_pkg::ST_IDLE) && !sclHeld;
  // reload on every cycle that the released line is still seen low
  assign counterReload = sclDrive && sclHeld;
  rate_counter u_rate (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .run         (counterRun),
    .reload      (counterReload),
    .reloadValue (rateReload),
    .rollover    (rollover)
  );

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  assign doWrite = haveAw && haveW && !s_axi_bvalid;
  // capture address and data in either order
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      haveAw        <= 1'b0;
      haveW         <= 1'b0;
      wrAddr        <= 5'h00;
      wrData        <= 32'h0000_0000;
      wrStrb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !haveAw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !haveW && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW  <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        haveAw       <= 1'b0;
        haveW        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrAddr[1:0] == 2'b00 && wrAddr <= `OFS_MASK)
                        ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign bufWrite = doWrite && wrStrb[0] && wrAddr == {1'b0, `OFS_BUFFER};
  assign ctlTwoWrite = doWrite && wrStrb[0]
                       && wrAddr == {1'b0, `OFS_CONTROL_TWO};

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  // one-cycle read answer; buffer read is the clearing event
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          {1'b0, `OFS_CONTROL_ONE}: begin
            s_axi_rdata <= {31'h0, portEnable};
          end
          {1'b0, `OFS_CONTROL_TWO}: begin
            s_axi_rdata <= {25'h0, sleepMode, ackValue, ackStart,
                            receiveStart, 3'h0};
          end
          {1'b0, `OFS_RATE}: begin
            s_axi_rdata <= {25'h0, rateReload};
          end
          {1'b0, `OFS_BUFFER}: begin
            s_axi_rdata <= {24'h0, serialBuffer};
          end
          `OFS_STATUS: begin
            s_axi_rdata <= {28'h0, status.collision, status.overflow,
                            status.irq, status.full};
          end
          `OFS_MASK: begin
            s_axi_rdata <= {28'h0, mask.collision, mask.overflow,
                            mask.irq, mask.full};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign bufRead = s_axi_arvalid && s_axi_arready
                   && s_axi_araddr == {1'b0, `OFS_BUFFER};

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  // software control; hardware clears start bits at sequence end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      portEnable   <= 1'b0;
      receiveStart <= 1'b0;
      ackStart     <= 1'b0;
      ackValue     <= 1'b0;
      sleepMode    <= 1'b0;
      rateReload   <= `RATE_RESET;
      mask         <= '0;
    end else begin
      if (doWrite && wrStrb[0] && wrAddr == {1'b0, `OFS_CONTROL_ONE}) begin
        portEnable <= wrData[`BIT_ENABLE];
      end
      if (doWrite && wrStrb[0] && wrAddr == {1'b0, `OFS_RATE}) begin
        rateReload <= wrData[6:0];
      end
      if (doWrite && wrStrb[0] && wrAddr == `OFS_MASK) begin
        mask <= {wrData[0], wrData[1], wrData[2], wrData[3]};
      end
      if (ctlTwoWrite) begin
        ackValue  <= wrData[`BIT_ACK_VALUE];
        sleepMode <= wrData[`BIT_SLEEP];
      end
      // start accepted only while enabled and idle
      if (ctlTwoWrite && portEnable && state == i2c_rx_pkg::ST_IDLE
          && !receiveStart && !ackStart) begin
        receiveStart <= wrData[`BIT_RECEIVE_START];
        ackStart     <= wrData[`BIT_ACK_START]
                        && !wrData[`BIT_RECEIVE_START];
      end else begin
        if (byteDone) begin
          receiveStart <= 1'b0;
        end
        if (state == i2c_rx_pkg::ST_ACK_END && rollover) begin
          ackStart <= 1'b0;
        end
      end
      if (!portEnable) begin
        receiveStart <= 1'b0;
        ackStart     <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // receive and acknowledge sequencer
  // ------------------------------------------------------------
  // eighth sample: the rollover that drops the clock after bit seven
  assign byteDone = state == i2c_rx_pkg::ST_RX_HIGH && rollover
                    && bitCount == (`EDGES_PER_BYTE - 4'h1);
  // each rollover toggles the clock line, except in ST_ACK_END, where it releases sda
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !portEnable) begin
      state    <= i2c_rx_pkg::ST_IDLE;
      sclDrive <= 1'b1;
      sdaOut   <= 1'b1;
      shiftIn  <= 8'h00;
      bitCount <= 4'h0;
    end else begin
      case (state)
        i2c_rx_pkg::ST_IDLE: begin
          sdaOut <= 1'b1;
          if (receiveStart) begin
            state    <= i2c_rx_pkg::ST_RX_LOW;
            bitCount <= 4'h0;
            sclDrive <= 1'b0;
          end else if (ackStart) begin
            state    <= i2c_rx_pkg::ST_ACK_LOW;
            sclDrive <= 1'b0;
            sdaOut   <= ackValue;
          end
        end
        i2c_rx_pkg::ST_RX_LOW: begin
          if (rollover) begin
            sclDrive <= 1'b1;
            state    <= i2c_rx_pkg::ST_RX_HIGH;
          end
        end
        i2c_rx_pkg::ST_RX_HIGH: begin
          if (rollover) begin
            // sample sda while clock high, msb first
            shiftIn  <= {shiftIn[6:0], sdaSync};
            bitCount <= bitCount + 4'h1;
            sclDrive <= 1'b0;
            if (bitCount + 4'h1 == `EDGES_PER_BYTE) begin
              state <= i2c_rx_pkg::ST_IDLE;
            end else begin
              state <= i2c_rx_pkg::ST_RX_LOW;
            end
          end
        end
        i2c_rx_pkg::ST_ACK_LOW: begin
          if (rollover) begin
            sclDrive <= 1'b1;
            state    <= i2c_rx_pkg::ST_ACK_HI;
          end
        end
        i2c_rx_pkg::ST_ACK_HI: begin
          if (rollover) begin
            sclDrive <= 1'b0;
            state    <= i2c_rx_pkg::ST_ACK_END;
          end
        end
        i2c_rx_pkg::ST_ACK_END: begin
          if (rollover) begin
            sdaOut <= 1'b1;
            state  <= i2c_rx_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= i2c_rx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // buffer and status flags
  // ------------------------------------------------------------
  // hardware set wins over software clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      serialBuffer <= 8'h00;
      status       <= '0;
    end else begin
      if (doWrite && wrAddr == `OFS_STATUS && wrStrb[0]) begin
        if (wrData[`ST_SERIAL_IRQ]) status.irq <= 1'b0;
        if (wrData[`ST_OVERFLOW]) status.overflow <= 1'b0;
        if (wrData[`ST_COLLISION]) status.collision <= 1'b0;
      end
      if (bufRead) begin
        status.full <= 1'b0;
      end
      if (bufWrite) begin
        if (state == i2c_rx_pkg::ST_RX_LOW
            || state == i2c_rx_pkg::ST_RX_HIGH) begin
          status.collision <= 1'b1;
        end else begin
          serialBuffer <= wrData[7:0];
        end
      end
      if (byteDone) begin
        serialBuffer <= {shiftIn[6:0], sdaSync};
        status.full  <= 1'b1;
        status.irq   <= 1'b1;
        if (status.full && !bufRead) begin
          status.overflow <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // pins and interrupt outputs
  // ------------------------------------------------------------
  // open drain: enable low while pulling low; wake in sleep mode
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclOut  <= 1'b0;
      sclOe_n <= 1'b1;
      sdaOe_n <= 1'b1;
      irq     <= 1'b0;
      wakeUp  <= 1'b0;
    end else begin
      sclOut  <= 1'b0;
      sclOe_n <= sclDrive;
      sdaOe_n <= sdaOut;
      irq     <= |(status & mask);
      wakeUp  <= sleepMode && status.irq && mask.irq;
    end
  end
endmodule
`default_nettype wire

//--- tb/i2c_rx_assertions.sv
// checker for the two-wire receive path, bound to its top module
// assumes a rate reload of at least 3 while the link runs
`timescale 1ns/100ps
`default_nettype none
module i2c_rx_assertions (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        sclIn,
  input wire logic        sclOe_n,
  input wire logic        sdaOe_n,
  input wire logic        irq,
  input wire logic        wakeUp
);
  default clocking cb @(posedge clk_sys); endclocking
  // ----------------------------------------
  // clock line shape and link pins
  // ----------------------------------------
  sequence s_hi; sclOe_n [*4]; endsequence
  sequence s_lo; !sclOe_n [*3]; endsequence
  property p_rst;
    sys_rst |=> sclOe_n && sdaOe_n && !irq && !wakeUp && !s_axi_bvalid
      && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not reset");
  property p_hold;
    disable iff (sys_rst) sclOe_n && !sclIn |=> sclOe_n;
  endproperty
  a_hold: assert property (p_hold) else $error("scl driven, held");
  property p_high;
    disable iff (sys_rst) $rose(sclOe_n) |-> s_hi;
  endproperty
  a_high: assert property (p_high) else $error("scl high too short");
  property p_low;
    disable iff (sys_rst) $fell(sclOe_n) |-> s_lo;
  endproperty
  a_low: assert property (p_low) else $error("scl low too short");
  property p_sda;
    disable iff (sys_rst) sclOe_n && $past(sclOe_n) |-> $stable(sdaOe_n);
  endproperty
  a_sda: assert property (p_sda) else $error("sda moved, scl high");
  property p_ackdrv;
    disable iff (sys_rst) $fell(sdaOe_n) |-> !sclOe_n;
  endproperty
  a_ackdrv: assert property (p_ackdrv) else $error("ack not on low");
  property p_wake;
    disable iff (sys_rst) wakeUp |-> irq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without irq");
  // ----------------------------------------
  // register bus answers
  // ----------------------------------------
  property p_bstand;
    disable iff (sys_rst) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bstand: assert property (p_bstand) else $error("bvalid dropped");
  property p_rstand;
    disable iff (sys_rst) s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rstand: assert property (p_rstand) else $error("rvalid dropped");
  property p_unmap;
    disable iff (sys_rst) s_axi_arvalid && s_axi_arready
      && s_axi_araddr > 5'h14
      |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind i2c_master_receive i2c_rx_assertions u_chk (.clk_sys, .sys_rst,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
  .s_axi_bready, .sclIn, .sclOe_n, .sdaOe_n, .irq, .wakeUp);
`default_nettype wire

//--- tb/i2c_slave_model.sv
// behavioural two-wire slave returning one byte per load pulse
// assumes scl and sda are the resolved wire levels with pull-ups
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       load,
  input  wire logic [7:0] byteVal,
  input  wire logic       slow,
  output var  logic       sdaRel,
  output var  logic       sclHold,
  output var  logic       ackBit,
  output var  logic       ackDone
);
  int bitCnt = 9;
  initial begin
    sdaRel = 1'b1;
    sclHold = 1'b0;
    ackBit = 1'b1;
    ackDone = 1'b0;
  end
  // new byte: first bit waits on the line
  always @(posedge load) begin
    bitCnt = 0;
    sdaRel = byteVal[7];
    ackDone = 1'b0;
  end
  // count high phases, catch the master's ack on the ninth
  always @(posedge scl) begin
    if (bitCnt == 8) begin
      ackBit = sda;
      ackDone = 1'b1;
    end
    bitCnt++;
  end
  // next bit after the fall, msb first, released after eight
  always @(negedge scl) begin
    #20;
    sdaRel = (bitCnt < 8) ? byteVal[7 - bitCnt] : 1'b1;
  end
  // slow mode stretches every low phase
  always @(negedge scl) begin
    if (slow) begin
      sclHold = 1'b1;
      #300;
      sclHold = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/i2c_master_receive_tb.sv
// self-checking bench for the two-wire master receive path
// assumes the register map header and a pull-up on both lines
`include "i2c_rx_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  miscompares++; $display("MISMATCH %s exp %h seen %h", n, e, s); end end
module i2c_master_receive_tb;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  awAddr  = 5'h00;
  logic [4:0]  arAddr  = 5'h00;
  logic [31:0] wData   = 32'h0;
  logic        awValid = 1'b0;
  logic        wValid  = 1'b0;
  logic        bReady  = 1'b0;
  logic        arValid = 1'b0;
  logic        rReady  = 1'b0;
  logic        load    = 1'b0;
  logic        slow    = 1'b0;
  logic [7:0]  byteVal = 8'h00;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp, rr, br;
  logic [31:0] rData, rv;
  logic        sclOut, sclOe_n, sdaOut, sdaOe_n, irq, wakeUp;
  logic        sdaRel, sclHold, ackBit, ackDone;
  wire         scl = sclOe_n & ~sclHold;
  wire         sda = sdaOe_n & sdaRel;
  int          miscompares = 0;
  int          total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  i2c_master_receive DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .sclIn(scl),
    .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .irq(irq), .wakeUp(wakeUp));
  i2c_slave_model slave (.scl(scl), .sda(sda), .load(load),
    .byteVal(byteVal), .slow(slow), .sdaRel(sdaRel), .sclHold(sclHold),
    .ackBit(ackBit), .ackDone(ackDone));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    br = bResp;
    bReady <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arReady === 1'b1) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rv = rData;
    rr = rResp;
    rReady <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [4:0] a,
                    input logic [31:0] e);
    rd(a);
    `CHK(n, e, rv)
  endtask
  // poll control two until the given bit clears
  task automatic waitClr(input int b);
    do rd(`OFS_CONTROL_TWO); while (rv[b] !== 1'b0);
  endtask
  task automatic go(input logic [7:0] b, input logic s,
                    input logic [31:0] c);
    @(posedge clk_sys);
    byteVal <= b;
    slow <= s;
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    wr(`OFS_CONTROL_TWO, c);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #400000;
    miscompares++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rc("ctrl2", `OFS_CONTROL_TWO, 32'h0);
    rc("rate", `OFS_RATE, {25'h0, `RATE_RESET});
    rc("status", `OFS_STATUS, 32'h0);
    rc("mask", `OFS_MASK, 32'h0);
    rd(5'h18);
    `CHK("unmapped", 2'b10, rr)
    wr(5'h18, 32'h0);
    `CHK("wrUnmapped", 2'b10, br)
    wr(`OFS_RATE, 32'h3);
    `CHK("bresp", 2'b00, br)
    wr(`OFS_MASK, 32'h2);
    wr(`OFS_CONTROL_ONE, 32'h1);
    // plain byte, then buffer read and ack low
    go(8'ha5, 1'b0, 32'h8);
    waitClr(`BIT_RECEIVE_START);
    `CHK("sclLow", 1'b0, sclOe_n)
    `CHK("sclOut", 1'b0, sclOut)
    `CHK("sdaOut", 1'b1, sdaOut)
    `CHK("irq", 1'b1, irq)
    rc("status", `OFS_STATUS, 32'h3);
    rc("buffer", `OFS_BUFFER, 32'ha5);
    rc("status", `OFS_STATUS, 32'h2);
    wr(`OFS_CONTROL_TWO, 32'h10);
    for (int k = 0; k < 2000 && ackDone !== 1'b1; k++) @(posedge clk_sys);
    `CHK("ackBit", 1'b0, ackBit)
    waitClr(`BIT_ACK_START);
    wr(`OFS_STATUS, 32'h2);
    repeat (2) @(posedge clk_sys);
    `CHK("irqClr", 1'b0, irq)
    // stretched byte with a colliding buffer write
    go(8'h3c, 1'b1, 32'h8);
    repeat (30) @(posedge clk_sys);
    wr(`OFS_BUFFER, 32'hff);
    rc("bufOld", `OFS_BUFFER, 32'ha5);
    waitClr(`BIT_RECEIVE_START);
    rc("status", `OFS_STATUS, 32'hb);
    wr(`OFS_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    `CHK("irqMask", 1'b0, irq)
    wr(`OFS_MASK, 32'h2);
    repeat (2) @(posedge clk_sys);
    `CHK("irqUnmask", 1'b1, irq)
    wr(`OFS_STATUS, 32'ha);
    rc("status", `OFS_STATUS, 32'h1);
    // byte in sleep on a full buffer, restart while busy
    go(8'h81, 1'b0, 32'h48);
    repeat (30) @(posedge clk_sys);
    wr(`OFS_CONTROL_TWO, 32'h48);
    waitClr(`BIT_RECEIVE_START);
    `CHK("wakeUp", 1'b1, wakeUp)
    rc("status", `OFS_STATUS, 32'h7);
    rc("buffer", `OFS_BUFFER, 32'h81);
    repeat (60) @(posedge clk_sys);
    `CHK("sclIdle", 1'b0, sclOe_n)
    rc("ctrl2", `OFS_CONTROL_TWO, 32'h40);
    // reset in mid-byte
    go(8'h55, 1'b0, 32'h8);
    repeat (40) @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    `CHK("sclRst", 1'b1, sclOe_n)
    rc("ctrl1", `OFS_CONTROL_ONE, 32'h0);
    rc("status", `OFS_STATUS, 32'h0);
    complete_run;
  end
endmodule
`default_nettype wire
